// >>> src/trp_pkg.sv
/*
  Shared constants for the threshold relay and peak control block:
  register map, control field positions, reset values, message codes,
  timing figures and the scaling helpers.
  Assumes a 10 MHz system clock and a 16-bit signed converter reading.
*/
package trp_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC_DEF = TICK_MS * 1000000 / CLK_NS;
  localparam int QUICK_MS = 5000;
  localparam int QUICK_TICKS = QUICK_MS / TICK_MS;
  localparam int MENU_MS = 2000;
  // One extra tick since the press may land anywhere inside a tick
  localparam int MENU_TICKS = MENU_MS / TICK_MS + 1;
  localparam int ID_MS = 2000;
  localparam int ID_TICKS = ID_MS / TICK_MS;
  localparam int UNIT_SEC_MULT = 10;

  // ------------------------------------------------------------
  // Displayable span
  // ------------------------------------------------------------
  localparam int SPAN_MIN = -999;
  localparam int SPAN_MAX = 9999;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TH1 = 8'h04;
  localparam logic [7:0] A_TH2 = 8'h08;
  localparam logic [7:0] A_HYS = 8'h0C;
  localparam logic [7:0] A_TON = 8'h10;
  localparam logic [7:0] A_TURN_OFF_DELAY = 8'h14;
  localparam logic [7:0] A_PEAK = 8'h18;
  localparam logic [7:0] A_RANGE = 8'h1C;
  localparam logic [7:0] A_SCALE = 8'h20;
  localparam logic [7:0] A_STAT = 8'h24;
  localparam logic [7:0] A_VALUE = 8'h28;

  // ------------------------------------------------------------
  // Control field positions and encodings
  // ------------------------------------------------------------
  localparam int B_FIT = 0;
  localparam int B_MODE = 1;
  localparam int B_SEL = 3;
  localparam int B_ACT = 4;
  localparam int B_HOLD = 6;
  localparam int B_SRC = 7;
  localparam int B_FREE = 8;
  localparam int B_UNIT = 9;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [1:0] ACT_ON = 2'h1;
  localparam logic [1:0] ACT_OFF = 2'h2;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] CTRL_RST = 16'h000B;
  localparam logic [15:0] RLO_RST = 16'h8000;
  localparam logic [15:0] RHI_RST = 16'h7FFF;
  localparam logic [15:0] GAIN_RST = 16'h0100;

  // ------------------------------------------------------------
  // Display message codes
  // ------------------------------------------------------------
  localparam logic [2:0] MSG_VAL = 3'h0;
  localparam logic [2:0] MSG_HI = 3'h1;
  localparam logic [2:0] MSG_LO = 3'h2;
  localparam logic [2:0] MSG_OV = 3'h3;
  localparam logic [2:0] MSG_NAME = 3'h4;
  localparam logic [2:0] MSG_ID = 3'h5;
  localparam logic [2:0] MSG_MENU = 3'h6;

  typedef enum logic [2:0] {ST_ID, ST_MEAS, ST_QUICK, ST_EDIT, ST_MENU}
    trp_state_e;

  // Reading times gain (Q8.8) plus offset
  function automatic int trp_scale(logic signed [15:0] raw,
                                   logic signed [15:0] g,
                                   logic signed [15:0] o);
    int p;
    p = int'(raw) * int'(g);
    return (p >>> 8) + int'(o);
  endfunction : trp_scale

  function automatic logic trp_ovf(int v);
    return (v < SPAN_MIN) || (v > SPAN_MAX);
  endfunction : trp_ovf

endpackage : trp_pkg

// >>> src/trp_core.sv
/*
  Threshold relay and peak control core: range and overflow messages,
  peak detection and hold, one relay channel with hysteresis and delays,
  quick threshold view and menu entry, AHB-Lite register slave.
  Assumes readings arrive on clk with a one-cycle valid; keys are raw
  pins, high while pressed; the menu engine lives elsewhere.
*/
// Functional notes
// - Out-of-range reading shows high or low message
// - In range but outside span shows overflow
// - Up/down key gives threshold quick view
// - Enter in quick view starts edit if free
// - Menu only after escape held two seconds
// - Measuring and relay keep running during configuration
// - Peak needs rise then fall by swing
// - Peak shown for set time, new restarts
// - Expired peak time returns to live value
// - Latching style, zero time holds until escape
// - Live style, zero time means no hold
// - Rightmost decimal point flashes while peak shown
// - Relay source selectable live or peak
// - Indicator follows relay, even when unfitted
// - Channel disabled, one or two thresholds
// - One threshold: selection sets zone A state
// - Two thresholds: energised inside or outside
// - Borders are threshold plus/minus hysteresis
// - Zero delays switch immediately at border
// - Non-zero delays need time past border
// - Short stay in zone keeps relay state
// - Critical state forces on, off or keep
`timescale 1ns/1ps
module trp_core
  import trp_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYC_DEF,
  parameter logic [15:0] FW_ID = 16'h0101 // Arbitrary value
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic signed [15:0] sampleRaw,
  input wire logic sampleValid,
  input wire logic keyUpPin,
  input wire logic keyDownPin,
  input wire logic keyEnterPin,
  input wire logic escapeMenuKeyPin,
  output logic signed [15:0] dispValue,
  output logic [2:0] dispMsg,
  output logic dispDp,
  output logic relayOut,
  output logic relayLed,
  output logic menuReq,
  output logic editReq,
  output logic quickIdx
);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (TICK_CYC < 2 || TICK_CYC >= 16777216) begin : g_chk
    $error("TICK_CYC out of range");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    trp_state_e st;
    logic idx;
    logic [7:0] tmr;
    logic [7:0] escCnt;
    logic [23:0] pre;
    logic [3:0] blk;
    logic [3:0] k1;
    logic [3:0] k2;
    logic [3:0] kp;
    logic [15:0] ctrl;
    logic signed [15:0] th1;
    logic signed [15:0] th2;
    logic signed [15:0] hys;
    logic [15:0] ton;
    logic [15:0] turn_off_delay;
    logic [15:0] swing;
    logic [15:0] pkTime;
    logic signed [15:0] rlo;
    logic signed [15:0] rhi;
    logic signed [15:0] gain;
    logic signed [15:0] offs;
    logic signed [15:0] live;
    logic liveOv;
    logic rangeHi;
    logic rangeLo;
    logic signed [15:0] pkRun;
    logic pkFall;
    logic signed [15:0] pkVal;
    logic pkOv;
    logic pkShown;
    logic [15:0] pkTmr;
    logic tgt;
    logic relay;
    logic [19:0] dly;
    logic signed [15:0] dispValue;
    logic [2:0] dispMsg;
    logic dispDp;
    logic relayOut;
    logic relayLed;
    logic menuReq;
    logic editReq;
    logic dph;
    logic [7:0] daddr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
  } trp_core_s;

  localparam trp_core_s RST = '{st: ST_ID, ctrl: CTRL_RST, rlo: RLO_RST,
    rhi: RHI_RST, gain: GAIN_RST, hreadyout: 1'b1, default: '0};

  trp_core_s r_reg;
  trp_core_s r_next;
  logic [3:0] edge_;
  logic tick;
  logic peakEv;
  logic crit;
  logic signed [15:0] srcV;

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    int s;
    int v;
    int lo;
    int hi;
    int h;
    logic mapped;
    logic sel;
    logic nt;
    logic [15:0] d;
    logic [19:0] lim;
    s = 0;
    v = 0;
    lo = 0;
    hi = 0;
    h = 0;
    nt = 1'b0;
    d = '0;
    lim = '0;
    mapped = 1'b0;
    sel = 1'b0;
    r_next = r_reg;
    r_next.menuReq = 1'b0;
    r_next.editReq = 1'b0;
    r_next.hreadyout = 1'b1;
    r_next.hresp = 1'b0;
    peakEv = 1'b0;
    // Key sync chain; only the second and third stages are looked at
    r_next.k1 = {keyUpPin, keyDownPin, keyEnterPin, escapeMenuKeyPin};
    r_next.k2 = r_reg.k1;
    r_next.kp = r_reg.k2;
    edge_ = r_reg.k2 & ~r_reg.kp;
    // Tenth-second time base
    tick = (r_reg.pre == 24'(TICK_CYC - 1));
    r_next.pre = tick ? '0 : r_reg.pre + 24'h000001;
    if (tick) begin
      r_next.blk = r_reg.blk + 4'h1;
    end

    // Bus writes land in the data phase; never stall the core
    if (r_reg.dph) begin
      case (r_reg.daddr)
        A_CTRL: r_next.ctrl = hwdata[15:0];
        A_TH1: r_next.th1 = hwdata[15:0];
        A_TH2: r_next.th2 = hwdata[15:0];
        A_HYS: r_next.hys = hwdata[15:0];
        A_TON: r_next.ton = hwdata[15:0];
        A_TURN_OFF_DELAY: r_next.turn_off_delay = hwdata[15:0];
        A_PEAK: {r_next.pkTime, r_next.swing} = hwdata;
        A_RANGE: {r_next.rhi, r_next.rlo} = hwdata;
        A_SCALE: {r_next.offs, r_next.gain} = hwdata;
        default: ;
      endcase
    end
    // Address phase; reads see a write from the cycle before
    sel = hsel && hready && htrans[1];
    mapped = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
    if (hready) begin
      r_next.dph = sel && hwrite && mapped;
      r_next.daddr = haddr[7:0];
      r_next.hrdata = '0;
      if (sel && !hwrite && mapped) begin
        case (haddr[7:0])
          A_CTRL: r_next.hrdata = {16'h0000, r_next.ctrl};
          A_TH1: r_next.hrdata = {16'h0000, r_next.th1};
          A_TH2: r_next.hrdata = {16'h0000, r_next.th2};
          A_HYS: r_next.hrdata = {16'h0000, r_next.hys};
          A_TON: r_next.hrdata = {16'h0000, r_next.ton};
          A_TURN_OFF_DELAY: r_next.hrdata = {16'h0000, r_next.turn_off_delay};
          A_PEAK: r_next.hrdata = {r_next.pkTime, r_next.swing};
          A_RANGE: r_next.hrdata = {r_next.rhi, r_next.rlo};
          A_SCALE: r_next.hrdata = {r_next.offs, r_next.gain};
          A_STAT: r_next.hrdata = {21'h000000, r_reg.st, 3'h0,
            r_reg.pkShown, r_reg.liveOv, r_reg.rangeLo, r_reg.rangeHi,
            r_reg.relay};
          A_VALUE: r_next.hrdata = {16'h0000, r_reg.live};
          default: r_next.hrdata = '0;
        endcase
      end
    end

    // Reading: range flags, scaling, peak tracking
    if (sampleValid) begin
      s = trp_scale(sampleRaw, r_reg.gain, r_reg.offs);
      r_next.rangeHi = sampleRaw > r_reg.rhi;
      r_next.rangeLo = sampleRaw < r_reg.rlo;
      r_next.live = 16'(s);
      r_next.liveOv = trp_ovf(s);
      // Falling phase follows the trough; rising phase the crest
      if (r_reg.pkFall) begin
        if (s < int'(r_reg.pkRun)) begin
          r_next.pkRun = 16'(s);
        end else if (s > int'(r_reg.pkRun)) begin
          r_next.pkFall = 1'b0;
          r_next.pkRun = 16'(s);
        end
      end else if (s > int'(r_reg.pkRun)) begin
        r_next.pkRun = 16'(s);
      end else if (int'(r_reg.pkRun) - s >= int'(r_reg.swing)) begin
        peakEv = 1'b1;
        r_next.pkVal = r_reg.pkRun;
        r_next.pkOv = trp_ovf(int'(r_reg.pkRun));
        r_next.pkFall = 1'b1;
        r_next.pkRun = 16'(s);
      end
    end

    // Peak hold: timed, latched, or none
    if (peakEv) begin
      if (r_reg.pkTime != 16'h0000 || r_reg.ctrl[B_HOLD]) begin
        r_next.pkShown = 1'b1;
        r_next.pkTmr = '0;
      end else begin
        r_next.pkShown = 1'b0;
      end
    end else if (r_reg.pkShown) begin
      if (r_reg.pkTime == 16'h0000) begin
        if (edge_[0] || !r_reg.ctrl[B_HOLD]) begin
          r_next.pkShown = 1'b0;
        end
      end else if (tick) begin
        r_next.pkTmr = r_reg.pkTmr + 16'h0001;
        if (r_next.pkTmr >= r_reg.pkTime) begin
          r_next.pkShown = 1'b0;
        end
      end
    end

    // Relay zone decision on live or held peak value
    srcV = (r_reg.ctrl[B_SRC] && r_reg.pkShown) ? r_reg.pkVal
                                                : r_reg.live;
    v = int'(srcV);
    h = int'(r_reg.hys);
    lo = (r_reg.th1 < r_reg.th2) ? int'(r_reg.th1) : int'(r_reg.th2);
    hi = (r_reg.th1 < r_reg.th2) ? int'(r_reg.th2) : int'(r_reg.th1);
    nt = r_reg.tgt;
    if (r_reg.ctrl[B_MODE +: 2] == MODE_TWO) begin
      if (v > lo + h && v < hi - h) begin
        nt = r_reg.ctrl[B_SEL];
      end else if (v < lo - h || v > hi + h) begin
        nt = !r_reg.ctrl[B_SEL];
      end
    end else if (v > int'(r_reg.th1) + h) begin
      nt = r_reg.ctrl[B_SEL];
    end else if (v < int'(r_reg.th1) - h) begin
      nt = !r_reg.ctrl[B_SEL];
    end
    d = nt ? r_reg.ton : r_reg.turn_off_delay;
    lim = r_reg.ctrl[B_UNIT] ? 20'(int'(d) * UNIT_SEC_MULT) : 20'(d);
    crit = r_reg.rangeHi || r_reg.rangeLo;
    if (r_reg.ctrl[B_MODE +: 2] == MODE_OFF) begin
      r_next.relay = 1'b0;
      r_next.tgt = 1'b0;
      r_next.dly = '0;
    end else if (crit) begin
      r_next.dly = '0;
      if (r_reg.ctrl[B_ACT +: 2] == ACT_ON) begin
        r_next.relay = 1'b1;
      end else if (r_reg.ctrl[B_ACT +: 2] == ACT_OFF) begin
        r_next.relay = 1'b0;
      end
    end else begin
      r_next.tgt = nt;
      if (nt == r_reg.relay) begin
        r_next.dly = '0;
      end else if (r_reg.dly >= lim) begin
        r_next.relay = nt;
        r_next.dly = '0;
      end else if (tick) begin
        r_next.dly = r_reg.dly + 20'h00001;
      end
    end
    // Indicator always follows; contact only when fitted
    r_next.relayLed = r_next.relay;
    r_next.relayOut = r_next.relay && r_reg.ctrl[B_FIT];

    // Front-panel key machine
    case (r_reg.st)
      ST_ID: begin
        if (tick) begin
          r_next.tmr = r_reg.tmr + 8'h01;
          if (r_reg.tmr == 8'(ID_TICKS - 1)) begin
            r_next.st = ST_MEAS;
            r_next.tmr = '0;
          end
        end
      end
      ST_MEAS: begin
        if (edge_[3] || edge_[2]) begin
          r_next.st = ST_QUICK;
          r_next.idx = 1'b0;
          r_next.tmr = '0;
          r_next.escCnt = '0;
        end else if (!r_reg.k2[0]) begin
          r_next.escCnt = '0;
        end else if (tick) begin
          r_next.escCnt = r_reg.escCnt + 8'h01;
          if (r_next.escCnt >= 8'(MENU_TICKS)) begin
            r_next.st = ST_MENU;
            r_next.menuReq = 1'b1;
            r_next.escCnt = '0;
          end
        end
      end
      ST_QUICK: begin
        if (edge_[3] || edge_[2]) begin
          r_next.idx = (r_reg.ctrl[B_MODE +: 2] == MODE_TWO) && !r_reg.idx;
          r_next.tmr = '0;
        end else if (edge_[1] && r_reg.ctrl[B_FREE]) begin
          r_next.st = ST_EDIT;
          r_next.editReq = 1'b1;
        end else if (edge_[0]) begin
          r_next.st = ST_MEAS;
        end else if (tick) begin
          r_next.tmr = r_reg.tmr + 8'h01;
          if (r_reg.tmr == 8'(QUICK_TICKS - 1)) begin
            r_next.st = ST_MEAS;
          end
        end
      end
      ST_EDIT: begin
        if (edge_[0] || edge_[1]) begin
          r_next.st = ST_MEAS;
        end
      end
      ST_MENU: begin
        if (edge_[0]) begin
          r_next.st = ST_MEAS;
        end
      end
      default: r_next.st = ST_MEAS;
    endcase

    // Display selection: state views first, then range messages, held peak, live overflow
    r_next.dispValue = r_reg.live;
    r_next.dispMsg = MSG_VAL;
    r_next.dispDp = 1'b0;
    if (r_reg.st == ST_ID) begin
      r_next.dispMsg = MSG_ID;
      r_next.dispValue = FW_ID;
    end else if (r_reg.st == ST_MENU) begin
      r_next.dispMsg = MSG_MENU;
    end else if (r_reg.st == ST_QUICK || r_reg.st == ST_EDIT) begin
      r_next.dispValue = r_reg.idx ? r_reg.th2 : r_reg.th1;
      if (r_reg.st == ST_QUICK && r_reg.blk[3]) begin
        r_next.dispMsg = MSG_NAME;
      end
    end else if (r_reg.rangeHi) begin
      r_next.dispMsg = MSG_HI;
    end else if (r_reg.rangeLo) begin
      r_next.dispMsg = MSG_LO;
    end else if (r_reg.pkShown) begin
      r_next.dispValue = r_reg.pkVal;
      r_next.dispMsg = r_reg.pkOv ? MSG_OV : MSG_VAL;
      r_next.dispDp = r_reg.blk[2];
    end else if (r_reg.liveOv) begin
      r_next.dispMsg = MSG_OV;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r_reg <= RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign hreadyout = r_reg.hreadyout;
  assign hresp = r_reg.hresp;
  assign hrdata = r_reg.hrdata;
  assign dispValue = r_reg.dispValue;
  assign dispMsg = r_reg.dispMsg;
  assign dispDp = r_reg.dispDp;
  assign relayOut = r_reg.relayOut;
  assign relayLed = r_reg.relayLed;
  assign menuReq = r_reg.menuReq;
  assign editReq = r_reg.editReq;
  assign quickIdx = r_reg.idx;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  range_hi_msg_a: assert property (r_reg.st == ST_MEAS && r_reg.rangeHi
    |=> dispMsg == MSG_HI) else $error("high message missing");
  ovf_msg_a: assert property (r_reg.st == ST_MEAS && !crit &&
    !r_reg.pkShown && r_reg.liveOv |=> dispMsg == MSG_OV)
    else $error("overflow message missing");
  quick_timeout_a: assert property (r_reg.st == ST_QUICK && tick &&
    r_reg.tmr == 8'(QUICK_TICKS - 1) && edge_ == 4'h0
    |=> r_reg.st == ST_MEAS) else $error("quick view stuck");
  edit_entry_a: assert property (r_reg.st == ST_QUICK &&
    edge_ == 4'h2 && r_reg.ctrl[B_FREE] |=> editReq)
    else $error("edit not started");
  menu_hold_a: assert property (menuReq |->
    $past(r_reg.escCnt) == 8'(MENU_TICKS - 1) && $past(r_reg.k2[0]))
    else $error("menu entered early");
  peak_swing_a: assert property (peakEv |->
    int'(r_reg.pkRun) - int'(r_next.live) >= int'(r_reg.swing))
    else $error("peak without swing");
  no_hold_a: assert property (!r_reg.ctrl[B_HOLD] &&
    r_reg.pkTime == 16'h0000 ##1 !r_reg.ctrl[B_HOLD] &&
    r_reg.pkTime == 16'h0000 |-> !r_reg.pkShown)
    else $error("peak held in live style");
  dp_flash_a: assert property (!r_reg.pkShown |=> !dispDp)
    else $error("dot without peak");
  zero_dly_a: assert property (r_reg.ctrl[B_MODE +: 2] != MODE_OFF &&
    !crit && r_reg.ton == 16'h0000 && r_reg.turn_off_delay == 16'h0000
    |=> r_reg.relay == r_reg.tgt && relayLed == r_reg.relay)
    else $error("zero delay not immediate");
  crit_on_a: assert property (crit && r_reg.ctrl[B_MODE +: 2] !=
    MODE_OFF && r_reg.ctrl[B_ACT +: 2] == ACT_ON |=> relayLed)
    else $error("critical on not forced");

  peak_seen_c: cover property (peakEv ##1 r_reg.pkShown);
  relay_on_c: cover property (!relayOut ##1 relayOut);
  menu_c: cover property (menuReq);
  quick_c: cover property (r_reg.st == ST_QUICK ##1 editReq);

endmodule : trp_core

// >>> tb/trp_adc_model.sv
/*
  Converter model for the threshold relay and peak control block.
  Assumes one clk domain; level is set by the bench at clock edges.
*/
`timescale 1ns/1ps
module trp_adc_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] level,
  output logic signed [15:0] sampleRaw,
  output logic sampleValid
);
  // ----------------------------------------
  // Conversion pacing
  // ----------------------------------------
  logic [2:0] phaseCnt;

  // One result each eight cycles; junk in between so stale data shows up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phaseCnt <= 3'h0;
      sampleValid <= 1'b0;
      sampleRaw <= 16'h0000;
    end else begin
      phaseCnt <= phaseCnt + 3'h1;
      sampleValid <= (phaseCnt == 3'h7);
      sampleRaw <= (phaseCnt == 3'h7) ? level : ~sampleRaw;
    end
  end
endmodule : trp_adc_model

// >>> tb/trp_core_tb_top.sv
/*
  Self-checking bench for trp_core: AHB-Lite master, converter model,
  key pins. Assumes the block is the only bus slave, short tick period.
*/
`timescale 1ns/1ps
module trp_core_tb_top
  import trp_pkg::*;
;
  // ----------------------------------------
  // Signals and stimulus tables
  // ----------------------------------------
  localparam int TK = 10;
  logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPh = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic hreadyout, hresp, keyUp = 1'b0, keyDown = 1'b0, escKey = 1'b0;
  logic keyEnter = 1'b0;
  logic [15:0] lvl = 16'h0000;
  logic signed [15:0] sampleRaw, dispValue;
  logic sampleValid, dispDp, relayOut, relayLed, menuReq, editReq, quickIdx;
  logic [2:0] dispMsg;
  logic [31:0] expQ[$];
  int n_mismatch = 0, check_count = 0, nMenu = 0, nDp = 0, nEdit = 0, v;
  logic [15:0] rawT[6] = '{16'h3001, 16'hEFFF, 16'h2710, 16'h270F,
                           16'hFC19, 16'hFC18};
  logic [2:0] msgT[6] = '{MSG_HI, MSG_LO, MSG_OV, MSG_VAL, MSG_VAL, MSG_OV};
  logic [7:0] ctlT[10] = '{8'h0B, 8'h0B, 8'h0B, 8'h0B, 8'h2B, 8'h1B,
                           8'h0D, 8'h0D, 8'h0D, 8'h09};
  logic [15:0] rlT[10] = '{16'h006F, 16'h0069, 16'h0059, 16'h0069,
                           16'h3001, 16'h3001, 16'h00C8, 16'h0140,
                           16'h00C8, 16'h00C8};
  logic relT[10] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0,
                     1'b1, 1'b0};

  trp_adc_model adc (.clk(clk), .rstn(rstn), .level(lvl),
    .sampleRaw(sampleRaw), .sampleValid(sampleValid));

  trp_core #(.TICK_CYC(TK)) dut (.clk(clk), .rstn(rstn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .sampleRaw(sampleRaw),
    .sampleValid(sampleValid), .keyUpPin(keyUp), .keyDownPin(keyDown),
    .keyEnterPin(keyEnter), .escapeMenuKeyPin(escKey),
    .dispValue(dispValue), .dispMsg(dispMsg), .dispDp(dispDp),
    .relayOut(relayOut), .relayLed(relayLed), .menuReq(menuReq),
    .editReq(editReq), .quickIdx(quickIdx));

  // Clock; watchdog far beyond the 1600 or so cycles of the run
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #(30000 * 100);
    n_mismatch++;
    test_done();
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmpWord
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Read data is taken at the edge that closes the data phase
  always @(posedge clk) begin
    if (rdPh && hreadyout === 1'b1) begin
      cmpWord(hrdata, expQ.pop_front());
      cmpWord({31'h0, hresp}, 32'h0);
    end
    if (menuReq === 1'b1) begin
      nMenu++;
    end
    nDp += int'(dispDp === 1'b1);
    nEdit += int'(editReq === 1'b1);
  end
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdPh <= !w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rdPh <= 1'b0;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic lv(input logic [15:0] x);
    @(posedge clk);
    lvl <= x;
    repeat (12) @(posedge clk);
  endtask : lv
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(83498));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(A_CTRL, 32'h0000000B);
    rd(A_RANGE, 32'h7FFF8000);
    rd(8'h40, 32'h0);
    chk(dispMsg, MSG_ID);
    repeat (ID_TICKS * TK + 10) @(posedge clk);
    v = $urandom % 1000;
    lv(v[15:0]);
    chk(dispMsg, MSG_VAL);
    chk(dispValue, v[15:0]);
    $display("reset test done");
    bus(1'b1, A_RANGE, 32'h3000F000);
    for (int i = 0; i < 6; i++) begin
      lv(rawT[i]);
      chk(dispMsg, msgT[i]);
    end
    $display("range test done");
    bus(1'b1, A_TH1, 32'd100);
    bus(1'b1, A_TH2, 32'd300);
    bus(1'b1, A_HYS, 32'd10);
    for (int i = 0; i < 10; i++) begin
      bus(1'b1, A_CTRL, {24'h0, ctlT[i]});
      lv(rlT[i]);
      chk(relayOut, relT[i]);
      chk(relayLed, relT[i]);
    end
    bus(1'b1, A_CTRL, 32'h0000000A);
    repeat (4) @(posedge clk);
    chk(relayOut, 1'b0);
    chk(relayLed, 1'b1);
    bus(1'b1, A_CTRL, 32'h0000000B);
    lv(16'd89);
    bus(1'b1, A_TON, 32'd3);
    bus(1'b1, A_TURN_OFF_DELAY, 32'd3);
    lv(16'd111);
    chk(relayOut, 1'b0);
    repeat (40) @(posedge clk);
    chk(relayOut, 1'b1);
    lv(16'd89);
    lv(16'd111);
    repeat (40) @(posedge clk);
    chk(relayOut, 1'b1);
    $display("relay test done");
    // Swing 20, hold 10 ticks: rise to 200, fall to 150
    bus(1'b1, A_PEAK, 32'h000A0014);
    lv(16'd200);
    lv(16'd150);
    chk(dispValue, 16'd200);
    repeat (120) @(posedge clk);
    chk(dispValue, 16'd150);
    chk(16'(nDp > 0), 16'h0001);
    chk(dispDp, 1'b0);
    lv(16'd111);
    $display("peak test done");
    // Two thresholds so the quick view can advance; free access on
    bus(1'b1, A_CTRL, 32'h0000010D);
    keyUp <= 1'b1;
    repeat (6) @(posedge clk);
    keyUp <= 1'b0;
    repeat (6) @(posedge clk);
    chk(quickIdx, 1'b0);
    keyDown <= 1'b1;
    repeat (6) @(posedge clk);
    keyDown <= 1'b0;
    repeat (6) @(posedge clk);
    chk(quickIdx, 1'b1);
    repeat (QUICK_TICKS * TK + 20) @(posedge clk);
    chk(dispMsg, MSG_VAL);
    chk(dispValue, 16'd111);
    keyUp <= 1'b1;
    repeat (6) @(posedge clk);
    keyUp <= 1'b0;
    repeat (6) @(posedge clk);
    keyEnter <= 1'b1;
    repeat (6) @(posedge clk);
    keyEnter <= 1'b0;
    repeat (6) @(posedge clk);
    chk(16'(nEdit), 16'h0001);
    escKey <= 1'b1;
    repeat (15 * TK) @(posedge clk);
    chk(16'(nMenu), 16'h0000);
    repeat ((MENU_TICKS - 13) * TK) @(posedge clk);
    chk(16'(nMenu), 16'h0001);
    escKey <= 1'b0;
    rd(A_VALUE, 32'd111);
    $display("keys test done");
    test_done();
  end
endmodule : trp_core_tb_top
